// *** hdl/enclave_trace_pkg.sv ***
/*
  Shared constants and carriers for the enclave branch-trace and counter gating block.
  Assumes one core clock and a 64-bit linear address space.
*/
package enclave_trace_pkg;

  localparam int IP_W = 64;
  localparam int DATA_W = 64;
  localparam int SIB_CTRS = 8;
  localparam int ADDR_W = 5;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_CTL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_FILTER = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_SIBLING = 5'h18;

  // Field positions.
  localparam int CTL_REC_EN = 0;
  localparam int FILTER_FAR = 8;
  localparam int STAT_IN_ENCL = 0;
  localparam int STAT_OPT_OUT = 1;
  localparam int STAT_GUARD = 60;
  localparam int SRC_PREDICTED = 63;
  localparam int FILTER_W = 16;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ENTER = 3'b001,
    OP_RESUME = 3'b010,
    OP_EXIT = 3'b011,
    OP_AEX = 3'b100,
    OP_LEAF = 3'b101,
    OP_EEE_END = 3'b110
  } op_kind_e;

  typedef struct packed {
    logic valid;
    op_kind_e kind;
    logic opt_out;
    logic [IP_W-1:0] ip;
    logic [IP_W-1:0] dest;
    logic [IP_W-1:0] ssa_ip;
    logic [IP_W-1:0] async_exit_resume_point;
  } op_s;

  typedef struct packed {
    logic valid;
    logic far;
    logic cause;
    logic in_txn;
    logic [IP_W-1:0] src;
    logic [IP_W-1:0] dst;
  } branch_s;

  typedef struct packed {
    logic valid;
    logic in_txn;
    logic [IP_W-1:0] src;
    logic [IP_W-1:0] dst;
  } record_s;

  typedef struct packed {
    logic valid;
    logic [IP_W-1:0] ip;
  } sample_s;

  typedef struct packed {
    logic in_encl;
    logic opt_out;
    logic rec_at_entry;
    logic cause_pend;
    logic [IP_W-1:0] entry_ip;
    logic [IP_W-1:0] async_exit_resume_point;
    logic rec_en;
    logic [FILTER_W-1:0] filter;
    logic guard;
    logic [SIB_CTRS-1:0] sib_any;
    logic [DATA_W-1:0] rd_data;
    record_s rec;
    sample_s sample;
  } state_s;

endpackage

// *** hdl/enclave_trace_gate.sv ***
/*
  Enclave branch-record and counter gating logic for one logical processor.
  Assumes the retirement logic presents at most one enclave operation or one ordinary
  branch per cycle on the core clock, and that pending sampling is a same-clock level.

  // Overview of operation
  // (R1) Opt-in enter/resume pushes op to destination.
  // (R2) Opt-in exit pushes exit to destination.
  // (R3) Opt-in async exit pushes saved pointer to resume.
  // (R4) Opt-in enclave branches recorded as usual.
  // (R5) Opt-out entry suppresses recording; exit lifts it.
  // (R6) Opt-out exit pushes entry address to destination.
  // (R7) Opt-out async exit pushes entry to resume first.
  // (R8) Causing event record sources from resume point.
  // (R9) Enclave records predicted, outside transactional region.
  // (R10) Enclave records are far, filter bit 8.
  // (R11) Status bit 60 flags counter interference.
  // (R12) Opt-in entry keeps counters, flag clear.
  // (R13) Opt-out entry stops thread counters, sets flag.
  // (R14) Opt-out enclave suppresses thread sampling records.
  // (R15) Sibling any-thread counters demoted during opt-out.
  // (R16) Any exit lifts counter and sampling suppression.
  // (R17) Exit restores sibling any-thread counting.
  // (R18) Leaf sample reports the leaf address.
  // (R19) Opt-in entry samples own address; opt-out none.
  // (R20) Exit sample: opt-in exit address.
  // (R21) Async exit sample: saved pointer or entry.
  // (R22) Sample after exiting event reports resume point.
  // (R23) Entry kind and address held until exit.
*/
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module enclave_trace_gate
  import enclave_trace_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Retirement events.
  input wire op_s op_i,
  input wire branch_s branch_i,
  input wire logic sample_pend_i,
  // Branch record stack push and sampling record.
  output record_s rec_o,
  output sample_s sample_o,
  // Counter gating.
  output logic thread_ctr_run_o,
  output logic sample_en_o,
  output logic [SIB_CTRS-1:0] sib_any_o,
  output logic [SIB_CTRS-1:0] sib_demoted_o
);

  state_s q;
  state_s d;
  logic susp;
  logic wr_stat;

  // Records from enclave operations are always predicted and non-transactional.
  function automatic record_s encl_rec(input logic [IP_W-1:0] src, input logic [IP_W-1:0] dst,
                                       input logic en, input logic [FILTER_W-1:0] filt);
    record_s r;
    r.valid = en & ~filt[FILTER_FAR]; // see (R10)
    r.in_txn = 1'b0; // see (R9)
    r.src = {1'b1, src[SRC_PREDICTED-1:0]}; // see (R9)
    r.dst = dst;
    return r;
  endfunction

  function automatic sample_s mk_sample(input logic en, input logic [IP_W-1:0] ip);
    sample_s s;
    s.valid = en;
    s.ip = ip;
    return s;
  endfunction

  assign susp = q.in_encl & q.opt_out;
  assign wr_stat = reg_wr_i && (reg_addr_i == OFF_STATUS);

  always_comb begin
    d = q;
    d.rec = '0;
    d.sample = '0;
    d.rd_data = '0;
    // The flag is write-one-to-clear; a set in the same cycle wins below.
    if (wr_stat && reg_wdata_i[STAT_GUARD]) begin
      d.guard = 1'b0;
    end
    if (reg_wr_i && reg_addr_i == OFF_CTL) begin
      d.rec_en = reg_wdata_i[CTL_REC_EN];
    end
    if (reg_wr_i && reg_addr_i == OFF_FILTER) begin
      d.filter = reg_wdata_i[FILTER_W-1:0];
    end
    if (reg_wr_i && reg_addr_i == OFF_SIBLING) begin
      d.sib_any = reg_wdata_i[SIB_CTRS-1:0];
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFF_CTL: d.rd_data[CTL_REC_EN] = q.rec_en;
        OFF_FILTER: d.rd_data[FILTER_W-1:0] = q.filter;
        OFF_STATUS: begin
          d.rd_data[STAT_GUARD] = q.guard; // see (R11)
          d.rd_data[STAT_IN_ENCL] = q.in_encl;
          d.rd_data[STAT_OPT_OUT] = q.opt_out;
        end
        OFF_SIBLING: d.rd_data[SIB_CTRS-1:0] = q.sib_any;
        default: d.rd_data = '0;
      endcase
    end
    if (op_i.valid) begin
      unique case (op_i.kind)
        OP_ENTER, OP_RESUME: begin
          d.in_encl = 1'b1; // see (R23)
          d.opt_out = op_i.opt_out;
          d.entry_ip = op_i.ip;
          d.rec_at_entry = q.rec_en;
          d.cause_pend = 1'b0;
          if (op_i.opt_out) begin
            d.guard = 1'b1; // see (R13)
          end else begin
            d.rec = encl_rec(op_i.ip, op_i.dest, q.rec_en, q.filter); // see (R1)
          end
          d.sample = mk_sample(sample_pend_i & ~op_i.opt_out, op_i.ip); // see (R19)
        end
        OP_EXIT: begin
          if (q.opt_out) begin
            d.rec = encl_rec(q.entry_ip, op_i.dest, q.rec_at_entry, q.filter); // see (R6)
            d.sample = mk_sample(sample_pend_i, q.entry_ip);
          end else begin
            d.rec = encl_rec(op_i.ip, op_i.dest, q.rec_en, q.filter); // see (R2)
            d.sample = mk_sample(sample_pend_i, op_i.ip); // see (R20)
          end
          d.in_encl = 1'b0; // see (R5) (R16) (R17)
          d.opt_out = 1'b0;
        end
        OP_AEX: begin
          if (q.opt_out) begin
            d.rec = encl_rec(q.entry_ip, op_i.async_exit_resume_point, q.rec_at_entry, q.filter); // see (R7)
            d.cause_pend = 1'b1;
            d.sample = mk_sample(sample_pend_i, q.entry_ip); // see (R21)
          end else begin
            d.rec = encl_rec(op_i.ssa_ip, op_i.async_exit_resume_point, q.rec_en, q.filter); // see (R3)
            d.sample = mk_sample(sample_pend_i, op_i.ssa_ip); // see (R21)
          end
          d.async_exit_resume_point = op_i.async_exit_resume_point;
          d.in_encl = 1'b0; // see (R16)
          d.opt_out = 1'b0;
        end
        OP_LEAF: begin
          // A leaf retiring inside an opt-out enclave must not leak a sampling record.
          d.sample = mk_sample(sample_pend_i & ~susp, op_i.ip); // see (R18) (R14)
        end
        OP_EEE_END: begin
          d.sample = mk_sample(sample_pend_i, q.async_exit_resume_point); // see (R22)
          d.cause_pend = 1'b0;
        end
        default: d.sample = '0;
      endcase
    end else if (branch_i.valid && q.rec_en && !susp) begin
      // Ordinary branches stay silent inside an opt-out enclave.
      d.rec.valid = ~(branch_i.far & q.filter[FILTER_FAR]); // see (R4) (R5)
      d.rec.in_txn = branch_i.in_txn;
      d.rec.src = branch_i.src;
      d.rec.dst = branch_i.dst;
      if (q.cause_pend && branch_i.cause) begin
        d.rec.src = q.async_exit_resume_point; // see (R8)
        d.rec.in_txn = 1'b0;
        d.cause_pend = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rd_data;
  assign rec_o = q.rec;
  assign sample_o = q.sample;
  // Cycle-counting fixed counters are never gated, so they need no control here.
  assign thread_ctr_run_o = ~susp; // see (R12) (R13) (R16)
  assign sample_en_o = ~susp; // see (R14) (R16)
  assign sib_any_o = q.sib_any & {SIB_CTRS{~susp}}; // see (R15) (R17)
  assign sib_demoted_o = q.sib_any & {SIB_CTRS{susp}}; // see (R15)

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  logic optin_entry;
  logic nofilt;
  assign optin_entry = op_i.valid && !op_i.opt_out &&
                       (op_i.kind == OP_ENTER || op_i.kind == OP_RESUME);
  assign nofilt = !q.filter[FILTER_FAR];

  AST_OPTIN_ENTRY_REC: assert property (optin_entry && q.rec_en && nofilt |=> // see (R1)
    rec_o.valid && rec_o.src[SRC_PREDICTED] && !rec_o.in_txn &&
    rec_o.dst == $past(op_i.dest)) else $error("opt-in entry record wrong");
  AST_OPTIN_EXIT_REC: assert property (op_i.valid && op_i.kind == OP_EXIT && q.in_encl && // see (R2)
    !q.opt_out && q.rec_en && nofilt |=> rec_o.valid &&
    rec_o.src[SRC_PREDICTED-1:0] == $past(op_i.ip[SRC_PREDICTED-1:0]))
    else $error("opt-in exit record wrong");
  AST_OPTIN_AEX_REC: assert property (op_i.valid && op_i.kind == OP_AEX && !q.opt_out && // see (R3)
    q.rec_en && nofilt |=> rec_o.valid && rec_o.dst == $past(op_i.async_exit_resume_point) &&
    rec_o.src[SRC_PREDICTED-1:0] == $past(op_i.ssa_ip[SRC_PREDICTED-1:0]))
    else $error("opt-in async exit record wrong");
  AST_OPTOUT_SILENT: assert property (susp && !op_i.valid |=> !rec_o.valid) // see (R5)
    else $error("record pushed inside opt-out enclave");
  AST_OPTOUT_EXIT_REC: assert property (op_i.valid && op_i.kind == OP_EXIT && susp && // see (R6)
    q.rec_at_entry && nofilt |=> rec_o.valid &&
    rec_o.src[SRC_PREDICTED-1:0] == $past(q.entry_ip[SRC_PREDICTED-1:0]))
    else $error("opt-out exit record wrong");
  AST_CAUSE_FROM_AEP: assert property (q.cause_pend && !op_i.valid && branch_i.valid && // see (R8)
    branch_i.cause && q.rec_en && !branch_i.far |=> rec_o.valid && rec_o.src == $past(q.async_exit_resume_point))
    else $error("causing record source not resume point");
  AST_FAR_FILTER: assert property (op_i.valid && op_i.kind != OP_LEAF && // see (R10)
    op_i.kind != OP_EEE_END && !nofilt |=> !rec_o.valid)
    else $error("far filter ignored");
  AST_OPTOUT_GATE: assert property (op_i.valid && op_i.opt_out && op_i.kind == OP_ENTER |=> // see (R13)
    q.guard && !thread_ctr_run_o && !sample_en_o) else $error("opt-out gating missing");
  AST_OPTIN_NO_FLAG: assert property (optin_entry && !q.guard && !wr_stat |=> !q.guard) // see (R12)
    else $error("flag set on opt-in entry");
  AST_EXIT_LIFTS: assert property (susp && op_i.valid && // see (R16)
    (op_i.kind == OP_EXIT || op_i.kind == OP_AEX) |=> thread_ctr_run_o && sample_en_o &&
    sib_demoted_o == '0) else $error("suppression not lifted");
  AST_AEX_SAMPLE: assert property (op_i.valid && op_i.kind == OP_AEX && susp && // see (R21)
    sample_pend_i |=> sample_o.valid && sample_o.ip == $past(q.entry_ip))
    else $error("async exit sample pointer wrong");
  AST_OPTOUT_NO_SAMPLE: assert property (op_i.valid && op_i.opt_out && // see (R19)
    op_i.kind == OP_RESUME |=> !sample_o.valid) else $error("opt-out entry sampled");
  AST_OPTOUT_LEAF_SILENT: assert property (susp && op_i.valid && op_i.kind == OP_LEAF |=> // see (R14)
    !sample_o.valid) else $error("sample inside opt-out enclave");

  COV_OPTOUT_AEX: cover property (susp ##1 op_i.valid && op_i.kind == OP_AEX);
  COV_OPTIN_EXIT: cover property (q.in_encl && !q.opt_out && op_i.kind == OP_EXIT && op_i.valid);
  COV_SIB_DEMOTE: cover property (sib_demoted_o != '0);

endmodule // enclave_trace_gate

// *** sim/tb.sv ***
/*
  Self-checking bench for the enclave trace gate, with a small reference model of its state.
  Assumes one-cycle answers on records, samples and register reads, and gating from registers.
*/
`timescale 1ns/1ps
module tb;
  import enclave_trace_pkg::*;
  logic clock_i, rst_n_i, reg_wr_i, reg_rd_i, sample_pend_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  op_s op_i;
  branch_s branch_i;
  record_s rec_o;
  sample_s sample_o;
  logic thread_ctr_run_o, sample_en_o;
  logic [SIB_CTRS-1:0] sib_any_o, sib_demoted_o, sib;
  int error_cnt, tests_run;
  bit in_encl, oo, rec_en, far_filt, guard, rec_at;
  logic [IP_W-1:0] entry_ip, last_aep;
  localparam logic [63:0] SMASK = (64'h1 << STAT_GUARD) | 64'h1;

  enclave_trace_gate u_enclave_trace_gate (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .op_i(op_i), .branch_i(branch_i),
    .sample_pend_i(sample_pend_i), .rec_o(rec_o), .sample_o(sample_o),
    .thread_ctr_run_o(thread_ctr_run_o), .sample_en_o(sample_en_o),
    .sib_any_o(sib_any_o), .sib_demoted_o(sib_demoted_o));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic fail(string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_val(logic [63:0] got, logic [63:0] exp, string m);
    tests_run++;
    if (got !== exp) fail(m);
  endtask
  task automatic chk_rec(record_s e);
    tests_run++;
    if (rec_o.valid !== e.valid || (e.valid && rec_o !== e)) fail("branch record");
  endtask
  task automatic chk_smp(sample_s e);
    tests_run++;
    if (sample_o.valid !== e.valid || (e.valid && sample_o !== e)) fail("sample record");
  endtask
  task automatic gate();
    bit x;
    x = in_encl && oo;
    chk_val(64'({thread_ctr_run_o, sample_en_o, sib_any_o, sib_demoted_o}),
      64'({!x, !x, x ? 8'h00 : sib, x ? sib : 8'h00}), "gating");
  endtask
  function automatic logic [63:0] st();
    return (64'(guard) << STAT_GUARD) | 64'(in_encl);
  endfunction
  task automatic note(string s);
    $display("Test %s done, errors %0d", s, error_cnt);
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [63:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [63:0] m, logic [63:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk_val(reg_rdata_o & m, e, "register read");
  endtask

  task automatic do_op(op_kind_e k, bit o, bit pend);
    op_s op;
    record_s er;
    sample_s es;
    bit x;
    op = '{1'b1, k, o, {$urandom, $urandom}, {$urandom, $urandom}, {$urandom, $urandom},
      {$urandom, $urandom}};
    x = in_encl && oo;
    er = '0;
    es = '0;
    case (k)
      OP_ENTER, OP_RESUME: begin
        er = '{rec_en && !o, 1'b0, op.ip, op.dest};
        es = '{pend && !o, op.ip};
        in_encl = 1'b1;
        oo = o;
        entry_ip = op.ip;
        rec_at = rec_en;
        guard = guard | o;
      end
      OP_EXIT, OP_AEX: begin
        er = '{x ? rec_at : rec_en, 1'b0, x ? entry_ip : (k == OP_EXIT ? op.ip : op.ssa_ip),
          k == OP_EXIT ? op.dest : op.async_exit_resume_point};
        es = '{pend, er.src};
        in_encl = 1'b0;
        last_aep = op.async_exit_resume_point;
      end
      OP_LEAF: es = '{pend && !x, op.ip};
      default: es = '{pend, last_aep};
    endcase
    er.src[SRC_PREDICTED] = 1'b1;
    if (far_filt) er.valid = 1'b0;
    @(posedge clock_i);
    op_i <= op;
    sample_pend_i <= pend;
    @(posedge clock_i);
    op_i.valid <= 1'b0;
    sample_pend_i <= 1'b0;
    #1;
    chk_rec(er);
    chk_smp(es);
    gate();
  endtask

  task automatic do_br(bit f, bit c);
    branch_s b;
    record_s er;
    b = '{1'b1, f, c, 1'b0, {$urandom, $urandom}, {$urandom, $urandom}};
    er = '{rec_en && !(in_encl && oo) && !(f && far_filt), 1'b0, c ? last_aep : b.src, b.dst};
    @(posedge clock_i);
    branch_i <= b;
    @(posedge clock_i);
    branch_i.valid <= 1'b0;
    #1;
    chk_rec(er);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    fail("watchdog expired");
    close_out();
  end

  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, sample_pend_i, reg_addr_i, reg_wdata_i} = '0;
    op_i = '0;
    branch_i = '0;
    sib = '0;
    void'($urandom(64900));
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
    gate();
    sib = 8'($urandom) | 8'h01;
    wr(OFF_SIBLING, 64'(sib));
    wr(OFF_CTL, 64'h1);
    rec_en = 1'b1;
    rd(OFF_SIBLING, '1, 64'(sib));
    rd(5'h04, '1, '0);
    note("registers");
    do_op(OP_ENTER, 1'b0, 1'b1);
    do_br(1'b0, 1'b0);
    rd(OFF_STATUS, SMASK, st());
    do_op(OP_EXIT, 1'b0, 1'b1);
    do_op(OP_LEAF, 1'b0, 1'b1);
    note("opt_in");
    do_op(OP_RESUME, 1'b1, 1'b1);
    rd(OFF_STATUS, SMASK, st());
    do_br(1'b0, 1'b0);
    do_op(OP_LEAF, 1'b0, 1'b1);
    wr(OFF_CTL, 64'h0);
    rec_en = 1'b0;
    do_op(OP_EXIT, 1'b0, 1'b1);
    do_br(1'b0, 1'b0);
    wr(OFF_CTL, 64'h1);
    rec_en = 1'b1;
    wr(OFF_STATUS, SMASK);
    guard = 1'b0;
    rd(OFF_STATUS, SMASK, st());
    note("opt_out_exit");
    do_op(OP_ENTER, 1'b1, 1'b0);
    do_op(OP_AEX, 1'b0, 1'b1);
    do_br(1'b0, 1'b1);
    do_op(OP_EEE_END, 1'b0, 1'b1);
    do_op(OP_RESUME, 1'b0, 1'b0);
    do_op(OP_AEX, 1'b0, 1'b1);
    note("async_exit");
    wr(OFF_FILTER, 64'h1 << FILTER_FAR);
    far_filt = 1'b1;
    rd(OFF_FILTER, '1, 64'h1 << FILTER_FAR);
    do_op(OP_ENTER, 1'b0, 1'b0);
    do_br(1'b1, 1'b0);
    do_br(1'b0, 1'b0);
    do_op(OP_EXIT, 1'b0, 1'b0);
    note("far_filter");
    close_out();
  end
endmodule // tb
